/* File: core/kps_map.svh */
// Register addresses, field positions, reset values and timing counts of the keypad
// scan size and column order block.
// Assumes an 8-bit special function register bus with 8-bit addresses.
`ifndef KPS_MAP_SVH
`define KPS_MAP_SVH

// Register addresses on the special function register bus
`define KPS_ADDR_SIZE       8'hd5
`define KPS_ADDR_ORDER_LOW  8'hd6
`define KPS_ADDR_ORDER_HIGH 8'hd7

// Reset values
`define KPS_SIZE_RST        8'h00
`define KPS_ORDER_LOW_RST   8'h00
`define KPS_ORDER_HIGH_RST  8'h00

// Field positions
`define KPS_ROW_MSB         5
`define KPS_ROW_LSB         3
`define KPS_COL_MSB         2
`define KPS_COL_LSB         0
`define KPS_SIZE_USED_MASK  8'h3f
`define KPS_ORDER_HIGH_MASK 8'h7f

// Keypad limits
`define KPS_MAX_ROWS        3'h6
`define KPS_MAX_COLS        3'h5
`define KPS_NUM_SLOTS       5
`define KPS_NUM_ROWS        6

// Time one column is driven before the rows are sampled
`define KPS_STEP_NS         1000
`define KPS_CLK_MHZ         200
`define KPS_STEP_CYC        ((`KPS_STEP_NS * `KPS_CLK_MHZ + 999) / 1000)

`endif

/* File: core/kps_pkg.sv */
// Types shared by the keypad scan size and column order block.
// Assumes kps_map.svh supplies the numeric constants.
package kps_pkg;

    typedef logic [2:0]  kps_slot_t;
    typedef logic [14:0] kps_order_t;

    typedef enum logic [1:0] {
        KPS_IDLE,
        KPS_SETTLE,
        KPS_SAMPLE
    } kps_state_t;

endpackage : kps_pkg

/* File: core/kps_slot_if.sv */
// Carrier between the scanner and the column order decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface kps_slot_if;
    kps_pkg::kps_order_t order;
    kps_pkg::kps_slot_t  slot_idx;
    kps_pkg::kps_slot_t  col_idx;
    logic [4:0]          col_onehot;

    modport pick (input order, input slot_idx, output col_idx, output col_onehot);
    modport user (output order, output slot_idx, input col_idx, input col_onehot);
endinterface : kps_slot_if

/* File: core/kps_order_dec.sv */
// Column order decoder: picks the slot named by the scanner and turns it into a
// column line index and a one-hot column drive.
// Assumes the scanner holds the slot index below the slot count.
`timescale 1ns/10ps
`include "kps_map.svh"
module kps_order_dec (
    kps_slot_if.pick sl
);

    kps_pkg::kps_slot_t slot_val [`KPS_NUM_SLOTS];
    logic [4:0]         line_hot;

    // Each slot is three bits of the packed order, first slot lowest
    for (genvar s = 0; s < `KPS_NUM_SLOTS; s++) begin : g_slot
        assign slot_val[s] = sl.order[3*s +: 3];
    end

    // Binary column number to a line; codes above four drive no line
    for (genvar c = 0; c < 5; c++) begin : g_line
        assign line_hot[c] = (sl.col_idx == 3'(c));
    end

    assign sl.col_idx    = slot_val[sl.slot_idx];
    assign sl.col_onehot = line_hot;

endmodule : kps_order_dec

/* File: core/kps_scan_top.sv */
// Keypad scan size and column order registers with the column stepping logic.
// Assumes the special function register bus is synchronous to clk, one access per
// cycle, and that row inputs are pulled up so a pressed key reads low.
//
// Summary of operation
// - Size bits 5:3 set rows, up to 6
// - Size bits 2:0 set columns, up to 5
// - Size only matters while hardware scan enabled
// - Fifteen-bit order: five three-bit column slots
// - Step slots first onward, wrap at column count
// - Low order: slot1 2:0, slot2 5:3, slot3 lsbs
// - Slot value is binary column line index
`timescale 1ns/10ps
`include "kps_map.svh"
module kps_scan_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       hardware_scan_mode_bit,
    input  wire logic [5:0] row_sense_n,
    output logic      [4:0] col_drive,
    output logic      [2:0] scan_slot,
    output logic      [5:0] row_hits,
    output logic            key_detect
);

    localparam logic [7:0] STEP_LAST = 8'(`KPS_STEP_CYC - 1);

    logic [7:0]          size_ff;
    logic [7:0]          nxt_size;
    logic [7:0]          order_low_ff;
    logic [7:0]          nxt_order_low;
    logic [7:0]          order_high_ff;
    logic [7:0]          nxt_order_high;
    logic [7:0]          sfr_rdata_ff;
    logic [7:0]          nxt_sfr_rdata;
    kps_pkg::kps_state_t state_ff;
    kps_pkg::kps_state_t nxt_state;
    kps_pkg::kps_slot_t  slot_ff;
    kps_pkg::kps_slot_t  nxt_slot;
    logic [7:0]          step_ff;
    logic [7:0]          nxt_step;
    logic [4:0]          col_drive_ff;
    logic [4:0]          nxt_col_drive;
    logic [5:0]          row_hits_ff;
    logic [5:0]          nxt_row_hits;
    logic                key_detect_ff;
    logic                nxt_key_detect;
    logic [2:0]          col_cnt;
    logic [2:0]          row_cnt;
    kps_pkg::kps_slot_t  last_slot;
    logic [2:0]          row_limit;
    logic [5:0]          row_mask;
    kps_pkg::kps_order_t order;

    kps_slot_if sl ();

    kps_order_dec kps_order_dec_inst (
        .sl (sl.pick)
    );

    // Register file writes; unused bits are held at zero
    always_comb begin
        nxt_size       = size_ff;
        nxt_order_low  = order_low_ff;
        nxt_order_high = order_high_ff;
        if (sfr_wr) begin
            case (sfr_addr)
                `KPS_ADDR_SIZE:       nxt_size       = sfr_wdata & `KPS_SIZE_USED_MASK;
                `KPS_ADDR_ORDER_LOW:  nxt_order_low  = sfr_wdata;
                `KPS_ADDR_ORDER_HIGH: nxt_order_high = sfr_wdata & `KPS_ORDER_HIGH_MASK;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses read as zero
    always_comb begin
        nxt_sfr_rdata = sfr_rdata_ff;
        if (sfr_rd) begin
            case (sfr_addr)
                `KPS_ADDR_SIZE:       nxt_sfr_rdata = size_ff;
                `KPS_ADDR_ORDER_LOW:  nxt_sfr_rdata = order_low_ff;
                `KPS_ADDR_ORDER_HIGH: nxt_sfr_rdata = order_high_ff;
                default:              nxt_sfr_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            size_ff       <= `KPS_SIZE_RST;
            order_low_ff  <= `KPS_ORDER_LOW_RST;
            order_high_ff <= `KPS_ORDER_HIGH_RST;
            sfr_rdata_ff  <= 8'h00;
        end else begin
            size_ff       <= nxt_size;
            order_low_ff  <= nxt_order_low;
            order_high_ff <= nxt_order_high;
            sfr_rdata_ff  <= nxt_sfr_rdata;
        end
    end

    // Packed order: slot three straddles both registers
    assign order = {order_high_ff[6:0], order_low_ff};

    // A zero or oversize count falls back to the full keypad rather than stall
    assign col_cnt   = size_ff[`KPS_COL_MSB:`KPS_COL_LSB];
    assign row_cnt   = size_ff[`KPS_ROW_MSB:`KPS_ROW_LSB];
    assign last_slot = (col_cnt == 3'h0 || col_cnt > `KPS_MAX_COLS) ?
                       3'(`KPS_MAX_COLS - 3'h1) : 3'(col_cnt - 3'h1);
    assign row_limit = (row_cnt == 3'h0 || row_cnt > `KPS_MAX_ROWS) ?
                       `KPS_MAX_ROWS : row_cnt;

    // Rows beyond the configured count are never reported
    for (genvar r = 0; r < `KPS_NUM_ROWS; r++) begin : g_row
        assign row_mask[r] = (3'(r) < row_limit);
    end

    // The decoder looks at the slot about to be driven
    assign sl.order    = order;
    assign sl.slot_idx = nxt_slot;

    // Scan sequencer: drive a column, let it settle, sample rows, step on
    always_comb begin
        nxt_state      = state_ff;
        nxt_slot       = slot_ff;
        nxt_step       = step_ff;
        nxt_row_hits   = row_hits_ff;
        nxt_key_detect = key_detect_ff;
        case (state_ff)
            kps_pkg::KPS_IDLE: begin
                nxt_slot = 3'h0;
                if (hardware_scan_mode_bit) begin
                    nxt_state = kps_pkg::KPS_SETTLE;
                    nxt_step  = STEP_LAST;
                end
            end
            kps_pkg::KPS_SETTLE: begin
                nxt_step = step_ff - 8'h01;
                if (step_ff == 8'h00) begin
                    nxt_state = kps_pkg::KPS_SAMPLE;
                end
            end
            kps_pkg::KPS_SAMPLE: begin
                nxt_row_hits   = ~row_sense_n & row_mask;
                nxt_key_detect = |(~row_sense_n & row_mask);
                nxt_slot       = (slot_ff >= last_slot) ? 3'h0 : 3'(slot_ff + 3'h1);
                nxt_step       = STEP_LAST;
                nxt_state      = kps_pkg::KPS_SETTLE;
            end
            default: begin
                nxt_state = kps_pkg::KPS_IDLE;
            end
        endcase
        // Leaving hardware scan drops all drive and ignores the size setting
        if (!hardware_scan_mode_bit) begin
            nxt_state      = kps_pkg::KPS_IDLE;
            nxt_slot       = 3'h0;
            nxt_step       = 8'h00;
            nxt_row_hits   = 6'h00;
            nxt_key_detect = 1'b0;
        end
    end

    // Column drive sits outside the sequencer so no process feeds its own inputs
    assign nxt_col_drive = (nxt_state == kps_pkg::KPS_IDLE) ? 5'h00 : sl.col_onehot;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff      <= kps_pkg::KPS_IDLE;
            slot_ff       <= 3'h0;
            step_ff       <= 8'h00;
            col_drive_ff  <= 5'h00;
            row_hits_ff   <= 6'h00;
            key_detect_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            slot_ff       <= nxt_slot;
            step_ff       <= nxt_step;
            col_drive_ff  <= nxt_col_drive;
            row_hits_ff   <= nxt_row_hits;
            key_detect_ff <= nxt_key_detect;
        end
    end

    assign sfr_rdata  = sfr_rdata_ff;
    assign col_drive  = col_drive_ff;
    assign scan_slot  = slot_ff;
    assign row_hits   = row_hits_ff;
    assign key_detect = key_detect_ff;

    // Checks on register layout and scan behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_row_field_write: assert property (
        sfr_wr && sfr_addr == `KPS_ADDR_SIZE |=> size_ff[5:3] == $past(sfr_wdata[5:3])
                                             && size_ff[7:6] == 2'b00)
        else $error("Row count field not stored");

    chk_col_field_read: assert property (
        sfr_rd && sfr_addr == `KPS_ADDR_SIZE && !sfr_wr |=> sfr_rdata[2:0] == size_ff[2:0])
        else $error("Column count field read back wrong");

    chk_disable_stops_scan: assert property (
        !hardware_scan_mode_bit |=> col_drive == 5'h00 && state_ff == kps_pkg::KPS_IDLE
                                && !key_detect)
        else $error("Scan active while hardware scan disabled");

    chk_single_column_drive: assert property (
        $onehot0(col_drive))
        else $error("More than one column driven");

    chk_slot_wrap_count: assert property (
        state_ff == kps_pkg::KPS_SAMPLE && slot_ff >= last_slot && hardware_scan_mode_bit
        |=> slot_ff == 3'h0 ##0 state_ff == kps_pkg::KPS_SETTLE)
        else $error("Slot did not wrap at column count");

    chk_low_order_layout: assert property (
        sfr_wr && sfr_addr == `KPS_ADDR_ORDER_LOW |=> order[7:0] == $past(sfr_wdata))
        else $error("Low order register layout wrong");

    chk_first_slot_drive: assert property (
        state_ff == kps_pkg::KPS_SETTLE && $past(state_ff) == kps_pkg::KPS_SETTLE
        && $stable(order) && slot_ff == 3'h0 && order[2:0] < 3'h5
        |-> col_drive == 5'(5'h01 << order[2:0]))
        else $error("First slot drives wrong column");

    chk_high_order_layout: assert property (
        sfr_wr && sfr_addr == `KPS_ADDR_ORDER_HIGH
        |=> order[14:8] == $past(sfr_wdata[6:0]) && order_high_ff[7] == 1'b0)
        else $error("High order register layout wrong");

    cov_scan_start:   cover property ($rose(hardware_scan_mode_bit) ##1 state_ff == kps_pkg::KPS_SETTLE);
    cov_full_wrap:    cover property (slot_ff == 3'h4 ##1 slot_ff == 3'h0);
    cov_key_detected: cover property ($rose(key_detect));
    cov_short_keypad: cover property (col_cnt == 3'h2 && slot_ff == 3'h1);

endmodule : kps_scan_top

/* File: tb/kps_key_matrix.sv */
// Passive key matrix model that sits on the row and column pins of the scanner.
// Assumes columns are driven high and that rows have pull-ups, so open rows read high.
`timescale 1ns/10ps
module kps_key_matrix (
    input  wire logic [4:0]  col_drive,
    input  wire logic [29:0] keys,
    output logic      [5:0]  row_sense_n
);
    // A row is pulled low only through a pressed key on a driven column
    always_comb begin
        for (int r = 0; r < 6; r++) begin
            row_sense_n[r] = ~|(keys[r*5 +: 5] & col_drive);
        end
    end
endmodule : kps_key_matrix

/* File: tb/kps_scan_top_tb.sv */
// Self-checking bench for the keypad scan size and column order block.
// Assumes the register map header and one 201-cycle step per scanned column.
`timescale 1ns/10ps
module kps_scan_top_tb;
    logic        clk                = 1'b0;
    logic        rst                = 1'b1;
    logic [7:0]  sfr_addr           = 8'h00;
    logic [7:0]  sfr_wdata          = 8'h00;
    logic        sfr_wr             = 1'b0;
    logic        sfr_rd             = 1'b0;
    logic        hardware_scan_mode_bit = 1'b0;
    logic [29:0] keys               = 30'h0;
    logic [7:0]  sfr_rdata;
    logic [5:0]  row_sense_n;
    logic [4:0]  col_drive;
    logic [2:0]  scan_slot;
    logic [5:0]  row_hits;
    logic        key_detect;
    int          n_errors           = 0;
    int          total_checks       = 0;
    int          cycle_count        = 0;
    // Expected drive per step: order 4,2,0 then code 7 (no line), then wrap to 4
    logic [4:0]  exp_cd [0:4]       = '{5'h10, 5'h04, 5'h01, 5'h00, 5'h10};
    logic [5:0]  exp_hit [0:4]      = '{6'h00, 6'h01, 6'h02, 6'h00, 6'h00};
    // Full keypad: order 1,0,4,3,2 then wrap to 1; keys at row 3 col 1 and row 5 col 4
    logic [4:0]  exp_cd2 [0:5]      = '{5'h02, 5'h01, 5'h10, 5'h08, 5'h04, 5'h02};
    logic [5:0]  exp_hit2 [0:5]     = '{6'h00, 6'h08, 6'h00, 6'h20, 6'h00, 6'h00};

    always #2.5 clk = ~clk;

    kps_scan_top kps_scan_top_inst (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .hardware_scan_mode_bit(hardware_scan_mode_bit), .row_sense_n(row_sense_n),
        .col_drive(col_drive), .scan_slot(scan_slot), .row_hits(row_hits),
        .key_detect(key_detect)
    );

    kps_key_matrix kps_key_matrix_inst (
        .col_drive(col_drive), .keys(keys), .row_sense_n(row_sense_n)
    );

    // Closing report, reached from the main sequence or from the hang guard
    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : check

    // One-cycle write strobe, launched and dropped at falling edges
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr    = 1'b0;
    endtask : write_reg

    // Read data lands at the same rising edge that takes the strobe
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd   = 1'b0;
        check(name, exp, sfr_rdata);
    endtask : read_check

    // Hang guard: the whole run needs under 3000 cycles
    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == 6000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // Register reset values, unused bits and an unmapped address
        read_check(8'hd5, 8'h00, "size reset");
        read_check(8'hd6, 8'h00, "order low reset");
        read_check(8'hd7, 8'h00, "order high reset");
        write_reg(8'hd5, 8'hff);
        read_check(8'hd5, 8'h3f, "size used bits");
        write_reg(8'hd7, 8'hff);
        check("rdata holds", 8'h3f, sfr_rdata);
        read_check(8'hd7, 8'h7f, "order high used bits");
        write_reg(8'hd4, 8'h5a);
        read_check(8'hd4, 8'h00, "unmapped read");
        $display("Test registers done");
        // Two rows, four columns; order is rewritten while idle, as firmware would
        write_reg(8'hd5, 8'h14);
        write_reg(8'hd6, 8'h14);
        write_reg(8'hd7, 8'h1e);
        read_check(8'hd6, 8'h14, "order low");
        keys = 30'h0;
        keys[0*5+4] = 1'b1;
        keys[1*5+2] = 1'b1;
        keys[4*5+2] = 1'b1;
        hardware_scan_mode_bit = 1'b1;
        // Look at the middle of each 201-cycle step, where nothing is changing
        repeat (101) @(negedge clk);
        for (int k = 0; k < 5; k++) begin
            check("col drive", {3'h0, exp_cd[k]}, {3'h0, col_drive});
            check("scan slot", 8'(k % 4), {5'h00, scan_slot});
            check("row hits", {2'h0, exp_hit[k]}, {2'h0, row_hits});
            check("key detect", {7'h00, |exp_hit[k]}, {7'h00, key_detect});
            repeat (201) @(negedge clk);
        end
        check("hits before stop", 8'h01, {2'h0, row_hits});
        $display("Test scan order done");
        // Dropping the enable clears all scan outputs; size is then ignored
        hardware_scan_mode_bit = 1'b0;
        @(negedge clk);
        check("stop drive", 8'h00, {3'h0, col_drive});
        check("stop slot", 8'h00, {5'h00, scan_slot});
        check("stop hits", 8'h00, {2'h0, row_hits});
        check("stop detect", 8'h00, {7'h00, key_detect});
        write_reg(8'hd5, 8'h00);
        repeat (300) @(negedge clk);
        check("idle drive", 8'h00, {3'h0, col_drive});
        $display("Test disable done");
        // Oversize rows and zero columns fall back to the full keypad; slot three
        // straddles both order registers and names column four here
        write_reg(8'hd5, 8'h38);
        write_reg(8'hd6, 8'h01);
        write_reg(8'hd7, 8'h27);
        keys = 30'h0;
        keys[5*5+4] = 1'b1;
        keys[3*5+1] = 1'b1;
        hardware_scan_mode_bit = 1'b1;
        repeat (101) @(negedge clk);
        for (int k = 0; k < 6; k++) begin
            check("full drive", {3'h0, exp_cd2[k]}, {3'h0, col_drive});
            check("full slot", 8'(k % 5), {5'h00, scan_slot});
            check("full hits", {2'h0, exp_hit2[k]}, {2'h0, row_hits});
            repeat (201) @(negedge clk);
        end
        $display("Test full keypad done");
        // Reset in mid-scan returns every register and output to zero
        rst = 1'b1;
        repeat (2) @(negedge clk);
        hardware_scan_mode_bit = 1'b0;
        rst = 1'b0;
        check("reset drive", 8'h00, {3'h0, col_drive});
        read_check(8'hd5, 8'h00, "size after reset");
        read_check(8'hd7, 8'h00, "order high after reset");
        $display("Test mid-run reset done");
        print_verdict();
    end
endmodule : kps_scan_top_tb
